// ==== osd_clock_control.sv ====
// Oscillator selection, slowdown and fast RC divide control registers on APB.
`include "osd_params.svh"

module osd_clock_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`OSD_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire osd_pkg::osd_src_t initial_source_config,
   input wire logic switch_monitor_config,
   input wire logic failsafe_monitor_fail,
   input wire logic interrupt_event,
   input wire logic new_source_stable_pin,
   input wire logic new_clock_pin,
   input wire logic pll_lock_pin,
   output osd_pkg::osd_ctrl_t clock_ctrl
);
   import osd_pkg::*;

   // ************************************************************
   // Pin synchronisers.
   // ************************************************************
   localparam int SYNC_N = 3;
   logic [SYNC_N-1:0] pin_raw; // Pins from other clock domains.
   logic [SYNC_N-1:0] sync1_ff; // First stage, read only by the second.
   logic [SYNC_N-1:0] sync2_ff; // Second stage.
   logic [SYNC_N-1:0] sync3_ff; // Third stage.
   logic [SYNC_N-1:0] pin_flt_ff; // Accepted level once stages two and three agree.

   assign pin_raw = {pll_lock_pin, new_clock_pin, new_source_stable_pin};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
         // Three flops per pin and a filter that updates only on agreement.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               sync3_ff[gi] <= 1'b0;
               pin_flt_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
               if (sync2_ff[gi] == sync3_ff[gi]) begin
                  pin_flt_ff[gi] <= sync2_ff[gi];
               end
            end
         end
      end
   endgenerate

   wire new_stable = pin_flt_ff[0]; // New source is running and stable.
   wire new_clk_lvl = pin_flt_ff[1]; // Filtered level of the new clock.
   wire pll_lvl = pin_flt_ff[2]; // Filtered PLL lock level.

   // ************************************************************
   // Register state.
   // ************************************************************
   osd_src_t cosc_ff; // Current source status.
   osd_src_t nosc_ff; // Next source selection.
   logic freeze_ff; // Selection freeze bit.
   logic lock_ff; // PLL-settled status.
   logic cf_ff; // Clock-failure flag.
   logic secondary_oscillator_ff; // Secondary oscillator enable.
   logic req_ff; // Switch request.
   logic roi_ff; // Recover on interrupt.
   logic [2:0] doze_ff; // Slowdown ratio code.
   logic slowdown_enable_ff; // Slowdown enable.
   logic [2:0] rcdiv_ff; // Fast RC postscaler code.
   logic [`OSD_TRIM_W-1:0] trim_ff; // Fast RC trim.
   logic strap_pending_ff; // Configuration still to be captured after reset.
   logic [1:0] hi_key_ff; // Upper byte unlock progress.
   logic [1:0] lo_key_ff; // Lower byte unlock progress.
   osd_sw_state_t sw_ff; // Switch sequencer state.
   logic [3:0] edge_cnt_ff; // New-clock edges seen while settling.
   logic new_clk_prev_ff; // Previous filtered new-clock level.
   logic [31:0] prdata_ff; // Read data latched in the setup phase.
   osd_ctrl_t ctrl_ff; // Registered control outputs.

   // ************************************************************
   // APB decode.
   // ************************************************************
   wire [`OSD_ADDR_W-1:0] word_addr = {paddr[`OSD_ADDR_W-1:2], 2'b00}; // Aligned address.
   wire hit_osc = (word_addr == `OSD_OFF_OSC); // Oscillator control selected.
   wire hit_div = (word_addr == `OSD_OFF_DIV); // Clock divider selected.
   wire hit_trim = (word_addr == `OSD_OFF_TRIM); // Trim register selected.
   wire hit_any = hit_osc | hit_div | hit_trim; // Any mapped register.
   wire setup_ph = psel & ~penable; // Setup cycle.
   wire access_ph = psel & penable; // Access cycle, always completed at once.
   wire wr_any = access_ph & pwrite; // Any write taking effect now.
   wire wr_osc = wr_any & hit_osc; // Write to oscillator control.
   wire wr_div = wr_any & hit_div; // Write to divider.
   wire wr_trim = wr_any & hit_trim; // Write to trim.
   wire [7:0] hi_byte = pwdata[15:8]; // Upper byte of written data.
   wire [7:0] lo_byte = pwdata[7:0]; // Lower byte of written data.
   wire wr_hi = wr_osc & pstrb[1]; // Upper byte lane written.
   wire wr_lo = wr_osc & pstrb[0]; // Lower byte lane written.

   assign pready = access_ph;
   assign pslverr = access_ph & ~hit_any;

   // ************************************************************
   // Unlock sequencing.
   // ************************************************************
   // Progress of a key pair: 0 idle, 1 first key seen, 2 armed for one write.
   function automatic logic [1:0] nxt_key(input logic [1:0] cur, input logic lane,
                                          input logic [7:0] data, input logic [7:0] k1,
                                          input logic [7:0] k2);
      logic [1:0] res;
      res = 2'h0;
      if (lane && cur == 2'h2) begin
         res = 2'h0;
      end else if (lane && data == k1) begin
         res = 2'h1;
      end else if (lane && cur == 2'h1 && data == k2) begin
         res = 2'h2;
      end
      return res;
   endfunction : nxt_key

   wire hi_open = wr_hi & (hi_key_ff == 2'h2); // Unlocked upper byte field write.
   wire lo_open = wr_lo & (lo_key_ff == 2'h2); // Unlocked lower byte field write.
   wire [1:0] nxt_hi_key = wr_any ? nxt_key(hi_key_ff, wr_hi, hi_byte, `OSD_KEY_HI_1,
                                            `OSD_KEY_HI_2) : hi_key_ff;
   wire [1:0] nxt_lo_key = wr_any ? nxt_key(lo_key_ff, wr_lo, lo_byte, `OSD_KEY_LO_1,
                                            `OSD_KEY_LO_2) : lo_key_ff;

   // ************************************************************
   // Selection control and switch sequencer.
   // ************************************************************
   wire switching_on = ~switch_monitor_config; // Switching and monitor enabled by strap.
   wire frozen = freeze_ff & switching_on;
   wire sw_idle = (sw_ff == OSD_SW_IDLE); // No switch in flight.
   wire same_src = (nosc_ff == cosc_ff); // Redundant switch.
   wire start_ok = sw_idle & req_ff & ~strap_pending_ff; // Request seen by sequencer.
   wire sw_abort = start_ok & same_src;
   wire sw_start = start_ok & ~same_src;
   wire needs_pll = (nosc_ff == OSD_SRC_PRIMARY_WITH_PLL) |
                    (nosc_ff == OSD_SRC_FAST_RC_WITH_PLL); // Target uses the PLL.
   wire new_edge = new_clk_lvl & ~new_clk_prev_ff; // Rising edge of the new clock.
   wire settle_done = (sw_ff == OSD_SW_SETTLE) & new_edge &
                      (edge_cnt_ff == `OSD_SETTLE_EDGES - 4'h1);
   wire req_set = lo_open & lo_byte[`OSD_OSC_REQ] & switching_on & ~frozen;
   wire req_clr = sw_abort | settle_done | ~switching_on;

   osd_sw_state_t nxt_sw; // Next sequencer state.
   // Sequencer: compare, wait for a stable source, count new-clock edges.
   always_comb begin
      nxt_sw = sw_ff;
      unique case (sw_ff)
         OSD_SW_IDLE: begin
            if (sw_start) begin
               nxt_sw = OSD_SW_WAIT_STABLE;
            end
         end
         OSD_SW_WAIT_STABLE: begin
            // A PLL target also waits for the lock to show.
            if (new_stable && (!needs_pll || pll_lvl)) begin
               nxt_sw = OSD_SW_SETTLE;
            end
         end
         OSD_SW_SETTLE: begin
            if (settle_done) begin
               nxt_sw = OSD_SW_IDLE;
            end
         end
      endcase
   end

   // Sequencer state, edge counter and new-clock edge detector.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_ff <= OSD_SW_IDLE;
         edge_cnt_ff <= 4'h0;
         new_clk_prev_ff <= 1'b0;
      end else begin
         sw_ff <= nxt_sw;
         new_clk_prev_ff <= new_clk_lvl;
         if (sw_ff != OSD_SW_SETTLE) begin
            edge_cnt_ff <= 4'h0;
         end else if (new_edge) begin
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
         end
      end
   end

   // ************************************************************
   // Oscillator control register.
   // ************************************************************
   // Source fields load from the configuration strap once reset is released.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_pending_ff <= 1'b1;
         cosc_ff <= OSD_SRC_FAST_RC;
         nosc_ff <= OSD_SRC_FAST_RC;
      end else if (strap_pending_ff) begin
         strap_pending_ff <= 1'b0;
         cosc_ff <= initial_source_config;
         nosc_ff <= initial_source_config;
      end else begin
         if (settle_done) begin
            cosc_ff <= nosc_ff;
         end
         if (hi_open && !frozen && sw_idle) begin
            nosc_ff <= osd_src_t'(hi_byte[2:0]);
         end
      end
   end

   // Status and control bits of the lower byte.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freeze_ff <= 1'b0;
         lock_ff <= 1'b0;
         cf_ff <= 1'b0;
         secondary_oscillator_ff <= 1'b0;
         req_ff <= 1'b0;
         hi_key_ff <= 2'h0;
         lo_key_ff <= 2'h0;
      end else begin
         hi_key_ff <= nxt_hi_key;
         lo_key_ff <= nxt_lo_key;
         // While switching is enabled a set freeze bit cannot itself be cleared.
         if (lo_open && !frozen) begin
            freeze_ff <= lo_byte[`OSD_OSC_FREEZE];
         end
         if (lo_open) begin
            secondary_oscillator_ff <= lo_byte[`OSD_OSC_SECONDARY_OSCILLATOR];
         end
         // A valid switch start clears the settled flag; it then follows the PLL.
         lock_ff <= sw_start ? 1'b0 : pll_lvl;
         // A detected failure wins over any clear in the same cycle.
         if (failsafe_monitor_fail) begin
            cf_ff <= 1'b1;
         end else if (sw_start || (lo_open && !lo_byte[`OSD_OSC_CF])) begin
            cf_ff <= 1'b0;
         end
         // A software set in the same cycle as a hardware clear is kept.
         if (req_set) begin
            req_ff <= 1'b1;
         end else if (req_clr) begin
            req_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Clock divider and trim registers.
   // ************************************************************
   // Byte-lane writes, with an interrupt able to drop the slowdown enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         roi_ff <= 1'b0;
         doze_ff <= `OSD_DOZE_RESET;
         slowdown_enable_ff <= 1'b0;
         rcdiv_ff <= `OSD_RCDIV_RESET;
         trim_ff <= `OSD_TRIM_RESET;
      end else begin
         if (wr_div && pstrb[1]) begin
            roi_ff <= pwdata[`OSD_DIV_ROI];
            doze_ff <= pwdata[`OSD_DIV_DOZE_LSB +: 3];
            rcdiv_ff <= pwdata[`OSD_DIV_RCDIV_LSB +: 3];
         end
         // The interrupt recovery clear wins over a simultaneous write.
         if (roi_ff && interrupt_event) begin
            slowdown_enable_ff <= 1'b0;
         end else if (wr_div && pstrb[1]) begin
            slowdown_enable_ff <= pwdata[`OSD_DIV_SLOWDOWN_ENABLE];
         end
         if (wr_trim && pstrb[0]) begin
            trim_ff <= pwdata[`OSD_TRIM_W-1:0];
         end
      end
   end

   // ************************************************************
   // Read data and control outputs.
   // ************************************************************
   wire [15:0] osc_word = {1'b0, cosc_ff, 1'b0, nosc_ff, freeze_ff, 1'b0, lock_ff, 1'b0,
                           cf_ff, 1'b0, secondary_oscillator_ff, req_ff};
   wire [15:0] div_word = {roi_ff, doze_ff, slowdown_enable_ff, rcdiv_ff, 8'h00};
   wire [15:0] trim_word = {10'h000, trim_ff};
   wire [15:0] rd_sel = hit_osc ? osc_word : hit_div ? div_word :
                        hit_trim ? trim_word : 16'h0000; // Selected read word.

   osd_ctrl_t nxt_ctrl; // Next value of the control outputs.
   assign nxt_ctrl.active_source = cosc_ff;
   assign nxt_ctrl.target_source = nosc_ff;
   assign nxt_ctrl.switch_busy = ~sw_idle;
   assign nxt_ctrl.secondary_osc_enable = secondary_oscillator_ff;
   assign nxt_ctrl.slowdown_log2 = slowdown_enable_ff ? doze_ff : 3'h0;
   assign nxt_ctrl.postscaler_log2 = rcdiv_ff;
   assign nxt_ctrl.trim = trim_ff;

   // Read data is latched in setup so it stands through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         ctrl_ff <= '0;
      end else begin
         if (setup_ph && !pwrite) begin
            prdata_ff <= {16'h0000, rd_sel};
         end
         ctrl_ff <= nxt_ctrl;
      end
   end
   assign prdata = prdata_ff;
   assign clock_ctrl = ctrl_ff;
endmodule : osd_clock_control

// ==== osd_params.svh ====
// Register offsets, field positions, reset values and counts of the clock control block.
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH

// ************************************************************
// Bus geometry and register offsets.
// ************************************************************
`define OSD_ADDR_W 12
`define OSD_OFF_OSC 12'h000
`define OSD_OFF_DIV 12'h004
`define OSD_OFF_TRIM 12'h008

// ************************************************************
// Oscillator control register fields.
// ************************************************************
`define OSD_OSC_COSC_LSB 12
`define OSD_OSC_NOSC_LSB 8
`define OSD_OSC_FREEZE 7
`define OSD_OSC_LOCK 5
`define OSD_OSC_CF 3
`define OSD_OSC_SECONDARY_OSCILLATOR 1
`define OSD_OSC_REQ 0

// ************************************************************
// Clock divider register fields and reset values.
// ************************************************************
`define OSD_DIV_ROI 15
`define OSD_DIV_DOZE_LSB 12
`define OSD_DIV_SLOWDOWN_ENABLE 11
`define OSD_DIV_RCDIV_LSB 8
`define OSD_RCDIV_RESET 3'h3
`define OSD_DOZE_RESET 3'h0
`define OSD_TRIM_W 6
`define OSD_TRIM_RESET 6'h00

// ************************************************************
// Unlock keys for the two halves of the oscillator control register.
// ************************************************************
`define OSD_KEY_HI_1 8'h78
`define OSD_KEY_HI_2 8'h9a
`define OSD_KEY_LO_1 8'h46
`define OSD_KEY_LO_2 8'h57

// ************************************************************
// Switch timing, counted in rising edges of the new clock.
// ************************************************************
`define OSD_SETTLE_EDGES 4'ha

`endif

// ==== osd_pkg.sv ====
// Types shared by the clock control block and its users.
package osd_pkg;

   // Three-bit source code used by the next-source and current-source fields.
   typedef enum logic [2:0] {
      OSD_SRC_FAST_RC = 3'h0,
      OSD_SRC_FAST_RC_WITH_PLL = 3'h1,
      OSD_SRC_PRIMARY = 3'h2,
      OSD_SRC_PRIMARY_WITH_PLL = 3'h3,
      OSD_SRC_SECONDARY_OSC = 3'h4,
      OSD_SRC_LOW_POWER_RC = 3'h5,
      OSD_SRC_RESERVED = 3'h6,
      OSD_SRC_FAST_RC_DIVIDED = 3'h7
   } osd_src_t;

   // Control word handed to the oscillators, dividers and clock gating.
   typedef struct packed {
      osd_src_t active_source;   // Source now driving the system clock.
      osd_src_t target_source;   // Source being brought up during a switch.
      logic switch_busy;         // A switch is in progress.
      logic secondary_osc_enable; // Keep the secondary oscillator running.
      logic [2:0] slowdown_log2; // Effective CPU to peripheral ratio as a power of two.
      logic [2:0] postscaler_log2; // Fast RC divisor as a power of two.
      logic [5:0] trim;          // Fast RC trim value.
   } osd_ctrl_t;

   // One-hot states of the switch sequencer.
   typedef enum logic [2:0] {
      OSD_SW_IDLE = 3'b001,
      OSD_SW_WAIT_STABLE = 3'b010,
      OSD_SW_SETTLE = 3'b100
   } osd_sw_state_t;

endpackage : osd_pkg

// ==== osd_clock_control_monitor.sv ====
// Concurrent checks on the ports of the clock control block.
`include "osd_params.svh"

// ************************************************************
// Checker module.
// ************************************************************
module osd_clock_control_monitor
   import osd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`OSD_ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic switch_monitor_config,
   input wire osd_pkg::osd_ctrl_t clock_ctrl
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // A read access cycle of each mapped register, where prdata is settled.
   sequence s_rd_osc;
      pready && !pwrite && paddr[11:2] == 10'h000;
   endsequence
   sequence s_rd_div;
      pready && !pwrite && paddr[11:2] == 10'h001;
   endsequence
   sequence s_rd_trim;
      pready && !pwrite && paddr[11:2] == 10'h002;
   endsequence

   // The access phase is answered at once and unmapped places are refused.
   chk_ready_access: assert property (psel && penable |-> pready)
      else $error("pready missing in access phase");
   chk_unmapped_err: assert property (pready && paddr[11:2] > 10'h002
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   chk_mapped_ok: assert property (pready && paddr[11:2] <= 10'h002 |-> !pslverr)
      else $error("mapped access refused");
   // Unimplemented positions read zero.
   chk_osc_reserved: assert property (s_rd_osc |-> prdata[31:15] == 17'h0 && !prdata[11]
      && !prdata[6] && !prdata[4] && !prdata[2]) else $error("osc reserved bit set");
   chk_div_low_zero: assert property (s_rd_div |-> prdata[7:0] == 8'h0)
      else $error("divider low byte not zero");
   chk_trim_upper: assert property (s_rd_trim |-> prdata[31:6] == 26'h0)
      else $error("trim upper bits not zero");
   // Register state and control word agree, both one cycle behind the same state.
   chk_ratio_forced: assert property (s_rd_div |-> prdata[11] || clock_ctrl.slowdown_log2 == 3'h0)
      else $error("ratio not forced to one");
   chk_ratio_select: assert property (s_rd_div |-> !prdata[11]
      || clock_ctrl.slowdown_log2 == prdata[14:12]) else $error("ratio not applied");
   chk_postscaler_out: assert property (s_rd_div |-> clock_ctrl.postscaler_log2 == prdata[10:8])
      else $error("postscaler not applied");
   chk_trim_out: assert property (s_rd_trim |-> clock_ctrl.trim == prdata[5:0])
      else $error("trim not applied");
   chk_secondary_oscillator_out: assert property (s_rd_osc |-> clock_ctrl.secondary_osc_enable == prdata[1])
      else $error("secondary enable not applied");
   chk_active_src: assert property (s_rd_osc |-> clock_ctrl.active_source == prdata[14:12])
      else $error("active source differs from status");
   // With switching disabled the request never reads set.
   chk_req_disabled: assert property (s_rd_osc ##0 switch_monitor_config
      && $past(switch_monitor_config, 2) |-> !prdata[0]) else $error("request set while disabled");
endmodule : osd_clock_control_monitor

bind osd_clock_control osd_clock_control_monitor osd_clock_control_monitor_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .switch_monitor_config(switch_monitor_config), .clock_ctrl(clock_ctrl));

// ==== test_osd_clock_control.sv ====
// Self-checking testbench of the clock control block.
`include "osd_params.svh"

// ************************************************************
// Testbench top.
// ************************************************************
module test_osd_clock_control;
   timeunit 1ns;
   timeprecision 1ps;
   import osd_pkg::*;

   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, d;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, er, mon_off = 1'b0, fail = 1'b0, irq = 1'b0;
   logic stable = 1'b0, nclk = 1'b0, pll = 1'b0;
   logic [2:0] strap, tgt, cand;
   osd_ctrl_t ctrl;
   int errors = 0, check_count = 0;

   osd_clock_control osd_clock_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .initial_source_config(osd_src_t'(strap)), .switch_monitor_config(mon_off),
      .failsafe_monitor_fail(fail), .interrupt_event(irq), .new_source_stable_pin(stable),
      .new_clock_pin(nclk), .pll_lock_pin(pll), .clock_ctrl(ctrl));

   // The bus clock toggles every 20 ns, a period of 40 ns.
   initial begin
      forever #20 pclk = ~pclk;
   end

   // Compares one value and counts the outcome.
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One APB transfer: setup, then access held until pready is sampled high.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait that never gets its answer.
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads a register and compares the masked word.
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(nm, e & m, rd & m);
   endtask : rdc

   // Writes a key pair to the upper or lower half of the oscillator register.
   task unlock(input logic hi);
      if (hi) begin
         apb(1'b1, `OSD_OFF_OSC, {16'h0, `OSD_KEY_HI_1, 8'h0}, 4'h2);
         apb(1'b1, `OSD_OFF_OSC, {16'h0, `OSD_KEY_HI_2, 8'h0}, 4'h2);
      end else begin
         apb(1'b1, `OSD_OFF_OSC, {24'h0, `OSD_KEY_LO_1}, 4'h1);
         apb(1'b1, `OSD_OFF_OSC, {24'h0, `OSD_KEY_LO_2}, 4'h1);
      end
   endtask : unlock

   // Makes rising edges of the slow new clock, eight bus cycles apart.
   task new_edges(input int n);
      repeat (n) begin
         repeat (4) @(posedge pclk);
         nclk <= 1'b1;
         repeat (4) @(posedge pclk);
         nclk <= 0;
      end
   endtask : new_edges

   // Pulses one same-clock input for one cycle.
   task pulse_irq();
      @(posedge pclk);
      irq <= 1'b1;
      @(posedge pclk);
      irq <= 1'b0;
   endtask : pulse_irq

   // Prints the counts and the verdict, then ends the run.
   task test_done();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   // Watchdog: the tests take well under 4000 cycles.
   initial begin
      #(40 * 20000);
      errors++;
      test_done();
   end

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      d = $urandom(16);
      strap = 3'($urandom);
      if (strap == 3'h6 || strap == 3'h4) strap = 3'h7;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      stable <= 1'b1;
      repeat (2) @(posedge pclk);
      rdc("osc reset", `OSD_OFF_OSC, 32'hffffffff, {17'h0, strap, 1'b0, strap, 8'h0});
      rdc("div reset", `OSD_OFF_DIV, 32'hffffffff, 32'h0300);
      rdc("trim reset", `OSD_OFF_TRIM, 32'hffffffff, 32'h0);
      $display("test reset done");
      // Random and corner values written and read back through the divider and trim.
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
         apb(1'b1, `OSD_OFF_DIV, d, 4'h3);
         rdc("div rw", `OSD_OFF_DIV, 32'hffff, d & 32'hff00);
         apb(1'b1, `OSD_OFF_TRIM, d, 4'h3);
         rdc("trim rw", `OSD_OFF_TRIM, 32'hffff, d & 32'h3f);
      end
      apb(1'b1, 12'h00c, 32'hffff, 4'h3);
      chk("unmapped err", 32'h1, {31'h0, er});
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      chk("unmapped rd", 32'h0, rd);
      rdc("div kept", `OSD_OFF_DIV, 32'hffff, d & 32'hff00);
      $display("test registers done");
      // Interrupt clears slowdown only when recovery is set.
      apb(1'b1, `OSD_OFF_DIV, 32'h8800, 4'h3);
      pulse_irq();
      rdc("roi clears", `OSD_OFF_DIV, 32'h0800, 32'h0);
      apb(1'b1, `OSD_OFF_DIV, 32'h0800, 4'h3);
      pulse_irq();
      rdc("roi off keeps", `OSD_OFF_DIV, 32'h0800, 32'h0800);
      $display("test interrupt done");
      // A locked write is ignored; then a full switch to the secondary oscillator.
      tgt = 3'h4;
      apb(1'b1, `OSD_OFF_OSC, {21'h0, tgt, 8'h0}, 4'h2);
      rdc("locked next", `OSD_OFF_OSC, 32'h0700, {21'h0, strap, 8'h0});
      unlock(1'b1);
      apb(1'b1, `OSD_OFF_OSC, {21'h0, tgt, 8'h0}, 4'h2);
      unlock(1'b0);
      apb(1'b1, `OSD_OFF_OSC, 32'h3, 4'h1);
      rdc("pending", `OSD_OFF_OSC, 32'h7703, {17'h0, strap, 1'b0, tgt, 8'h3});
      chk("busy", 32'h1, {31'h0, ctrl.switch_busy});
      new_edges(8);
      rdc("still pending", `OSD_OFF_OSC, 32'h7701, {17'h0, strap, 1'b0, tgt, 8'h1});
      new_edges(3);
      repeat (8) @(posedge pclk);
      rdc("switched", `OSD_OFF_OSC, 32'h7701, {17'h0, tgt, 1'b0, tgt, 8'h0});
      chk("active src", {29'h0, tgt}, {29'h0, ctrl.active_source});
      chk("idle", 32'h0, {31'h0, ctrl.switch_busy});
      $display("test switch done");
      // A request to the running source aborts.
      unlock(1'b0);
      apb(1'b1, `OSD_OFF_OSC, 32'h3, 4'h1);
      repeat (4) @(posedge pclk);
      rdc("abort", `OSD_OFF_OSC, 32'h7701, {17'h0, tgt, 1'b0, tgt, 8'h0});
      // Status flags follow the monitor and PLL inputs.
      pll <= 1'b1;
      @(posedge pclk);
      fail <= 1'b1;
      @(posedge pclk);
      fail <= 1'b0;
      repeat (6) @(posedge pclk);
      rdc("flags", `OSD_OFF_OSC, 32'h0028, 32'h0028);
      $display("test flags done");
      // Freeze holds the selection only while switching is enabled.
      cand = 3'h5;
      unlock(1'b0);
      apb(1'b1, `OSD_OFF_OSC, 32'h8a, 4'h1);
      unlock(1'b1);
      apb(1'b1, `OSD_OFF_OSC, {21'h0, cand, 8'h0}, 4'h2);
      rdc("frozen", `OSD_OFF_OSC, 32'h0780, {21'h0, tgt, 8'h80});
      mon_off <= 1'b1;
      repeat (2) @(posedge pclk);
      unlock(1'b1);
      apb(1'b1, `OSD_OFF_OSC, {21'h0, cand, 8'h0}, 4'h2);
      rdc("never locked", `OSD_OFF_OSC, 32'h0700, {21'h0, cand, 8'h0});
      chk("target src", {29'h0, cand}, {29'h0, ctrl.target_source});
      unlock(1'b0);
      apb(1'b1, `OSD_OFF_OSC, 32'h1, 4'h1);
      rdc("req held low", `OSD_OFF_OSC, 32'h0001, 32'h0);
      $display("test freeze done");
      test_done();
   end
endmodule : test_osd_clock_control
